// ===== src/usb_otg_config_irq_regs.sv
// register bank for usb otg configuration and otg event interrupts
//
// Behaviour
// - start-of-frame threshold holds size plus ten
// - eye test bit drives eye pattern
// - drive monitor output only with transceiver off
// - halt in idle stops module in idle
// - config bit 4 enables vbus pull-up
// - config bit 3 selects serial control
// - config bit 2 disables boost regulator
// - config bit 1 disables vbus comparator
// - id pin change sets flag bit 7
// - millisecond timer expiry sets bit 6
// - line state stable 1 ms, changed
// - bus or vbus activity sets bit 4
// - a session end crossing sets bit 3
// - b session end crossing sets bit 2
// - a vbus valid crossing sets bit 0
// - threshold flags set on either direction
// - write one clears flag, zeros keep
// - unimplemented bits read zero, ignore writes
// - power enable bit enables the module
//
// Design decisions made here: the register offsets and strobed register access.
module usb_otg_config_irq_regs
   import otg_regs_pkg::*;
(
   // clock and reset
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   // register port
   input wire logic [3:0] ADDR_IN,
   input wire logic [15:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [15:0] RDATA_OUT,
   // sensing pins and device state
   input wire sense_type SENSE_IN,
   input wire logic IDLE_MODE_IN,
   input wire logic LINE_DRIVING_IN,
   // configuration outputs
   output logic EYE_TEST_OUT,
   output logic DRIVE_MONITOR_OUT,
   output logic MODULE_RUN_OUT,
   output pingpong_type PINGPONG_OUT,
   output logic VBUS_PULLUP_OUT,
   output logic SERIAL_CTRL_OUT,
   output logic BOOST_DISABLE_OUT,
   output logic VCMP_DISABLE_OUT,
   output logic XCVR_DISABLE_OUT,
   output logic [7:0] FRAME_THRESHOLD_OUT,
   // interrupt request
   output logic OTG_IRQ_OUT
);
   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [7:0] frame_threshold_count;
   logic [15:0] usb_config_one;
   logic [15:0] usb_config_two;
   logic [15:0] otg_event_flags;
   logic [15:0] otg_event_enables;
   logic module_power_enable;
   logic [15:0] next_flags;
   logic [15:0] event_set;
   sense_type sync_a;
   sense_type sync_b;
   sense_type sense_prev;
   logic [31:0] ms_count;
   logic ms_tick;
   logic [31:0] stable_count;
   logic [1:0] line_now;
   logic [1:0] line_seen;
   logic [1:0] line_recorded;
   logic line_event;

   // write strobe decode, used for every register
   function automatic logic wr_hit(input logic [3:0] a,
                                   input logic [3:0] target,
                                   input logic w);
      wr_hit = w && (a == target);
   endfunction : wr_hit

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   // two stages; only sync_b and later are looked at
   // sense_prev is a third stage kept only for edge detection
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         sync_a <= '0;
         sync_b <= '0;
         sense_prev <= '0;
      end else begin
         sync_a <= SENSE_IN;
         sync_b <= sync_a;
         sense_prev <= sync_b;
      end
   end

   // ------------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------------
   // threshold byte
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         frame_threshold_count <= RESET_VALUE[7:0];
      end else if (wr_hit(ADDR_IN, ADDR_FRAME_THR, WR_IN)) begin
         frame_threshold_count <= WDATA_IN[7:0];
      end
   end

   // masks keep unimplemented bits at zero
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         usb_config_one <= RESET_VALUE;
      end else if (wr_hit(ADDR_IN, ADDR_CONFIG_ONE, WR_IN)) begin
         usb_config_one <= WDATA_IN & MASK_CONFIG_ONE;
      end
   end

   // software must not write disables while powered; not blocked
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         usb_config_two <= RESET_VALUE;
      end else if (wr_hit(ADDR_IN, ADDR_CONFIG_TWO, WR_IN)) begin
         usb_config_two <= WDATA_IN & MASK_CONFIG_TWO;
      end
   end

   // enables exist only where flags exist
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         otg_event_enables <= RESET_VALUE;
      end else if (wr_hit(ADDR_IN, ADDR_EVENT_EN, WR_IN)) begin
         otg_event_enables <= WDATA_IN & MASK_EVENTS;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         module_power_enable <= 1'b0;
      end else if (wr_hit(ADDR_IN, ADDR_POWER, WR_IN)) begin
         module_power_enable <= WDATA_IN[0];
      end
   end

   // ------------------------------------------------------------------
   // millisecond timer and line state
   // ------------------------------------------------------------------
   // free-running ms timer, only while powered
   // held clear while unpowered, so power-up waits one full period
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN || !module_power_enable) begin
         ms_count <= '0;
      end else if (ms_count == 32'(MS_CYCLES - 1)) begin
         ms_count <= '0;
      end else begin
         ms_count <= ms_count + 32'd1;
      end
   end
   assign ms_tick = module_power_enable
                    && (ms_count == 32'(MS_CYCLES - 1));

   // line state: single-ended zero and the j indication
   assign line_now = {sync_b.both_lines_low, sync_b.dplus};

   // stable for 1 ms and differing from the last stable state
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         line_seen <= '0;
         line_recorded <= '0;
         stable_count <= '0;
      end else begin
         line_seen <= line_now;
         if (line_now != line_seen) begin
            stable_count <= '0;
         end else if (stable_count == 32'(MS_CYCLES - 1)) begin
            line_recorded <= line_seen;
         end else begin
            stable_count <= stable_count + 32'd1;
         end
      end
   end
   assign line_event = (line_now == line_seen)
                       && (stable_count == 32'(MS_CYCLES - 1))
                       && (line_seen != line_recorded);

   // ------------------------------------------------------------------
   // event flags
   // ------------------------------------------------------------------
   // hardware set sources, each a one-cycle pulse
   always_comb begin
      event_set = '0;
      event_set[BIT_ID] = sync_b.id_pin ^ sense_prev.id_pin;
      event_set[BIT_MS] = ms_tick;
      event_set[BIT_LINE] = line_event;
      // any activity on lines or vbus
      event_set[BIT_ACT] = (sync_b.dplus ^ sense_prev.dplus)
                           | (sync_b.dminus ^ sense_prev.dminus)
                           | (sync_b.vbus_act ^ sense_prev.vbus_act);
      // either edge of each threshold comparator
      event_set[BIT_SESSV] = sync_b.a_sess_end ^ sense_prev.a_sess_end;
      event_set[BIT_BSEND] = sync_b.b_sess_end ^ sense_prev.b_sess_end;
      event_set[BIT_AVBUS] = sync_b.a_vbus_valid
                             ^ sense_prev.a_vbus_valid;
   end

   // write-one-to-clear; a set in the same cycle wins
   always_comb begin
      next_flags = otg_event_flags;
      if (wr_hit(ADDR_IN, ADDR_EVENT_FLAGS, WR_IN)) begin
         next_flags = next_flags & ~WDATA_IN;
      end
      next_flags = (next_flags | event_set) & MASK_EVENTS;
   end

   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         otg_event_flags <= RESET_VALUE;
      end else begin
         otg_event_flags <= next_flags;
      end
   end

   assign OTG_IRQ_OUT = |(otg_event_flags & otg_event_enables);

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------
   // data stands only in the cycle after the read strobe
   // zero otherwise, so a stale word never lingers on the bus
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN || !RD_IN) begin
         RDATA_OUT <= '0;
      end else begin
         case (ADDR_IN)
            ADDR_FRAME_THR: RDATA_OUT <= {8'h00, frame_threshold_count};
            ADDR_CONFIG_ONE: RDATA_OUT <= usb_config_one;
            ADDR_CONFIG_TWO: RDATA_OUT <= usb_config_two;
            ADDR_EVENT_FLAGS: RDATA_OUT <= otg_event_flags;
            ADDR_EVENT_EN: RDATA_OUT <= otg_event_enables;
            ADDR_POWER: RDATA_OUT <= {15'h0000, module_power_enable};
            default: RDATA_OUT <= '0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // configuration outputs
   // ------------------------------------------------------------------
   // threshold driven to the frame logic
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         FRAME_THRESHOLD_OUT <= '0;
         EYE_TEST_OUT <= 1'b0;
         DRIVE_MONITOR_OUT <= 1'b0;
         MODULE_RUN_OUT <= 1'b0;
         PINGPONG_OUT <= PP_NONE_type;
         VBUS_PULLUP_OUT <= 1'b0;
         SERIAL_CTRL_OUT <= 1'b0;
         BOOST_DISABLE_OUT <= 1'b0;
         VCMP_DISABLE_OUT <= 1'b0;
         XCVR_DISABLE_OUT <= 1'b0;
      end else begin
         FRAME_THRESHOLD_OUT <= frame_threshold_count;
         EYE_TEST_OUT <= usb_config_one[BIT_EYE];
         DRIVE_MONITOR_OUT <= usb_config_one[BIT_DRVMON]
                              && usb_config_two[BIT_XCVR_DIS]
                              && LINE_DRIVING_IN;
         // run when powered and not halted in idle
         MODULE_RUN_OUT <= module_power_enable
                           && !(usb_config_one[BIT_HALT_IDLE]
                                && IDLE_MODE_IN);
         PINGPONG_OUT <= pingpong_type'(usb_config_one[1:0]);
         VBUS_PULLUP_OUT <= usb_config_two[BIT_PULLUP];
         SERIAL_CTRL_OUT <= usb_config_two[BIT_SERIAL_SEL];
         BOOST_DISABLE_OUT <= usb_config_two[BIT_BOOST_DIS];
         VCMP_DISABLE_OUT <= usb_config_two[BIT_VCMP_DIS];
         XCVR_DISABLE_OUT <= usb_config_two[BIT_XCVR_DIS];
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);

   sequence clear_all_s;
      WR_IN && ADDR_IN == ADDR_EVENT_FLAGS && WDATA_IN == 16'hffff
      && event_set == 16'h0000;
   endsequence

   id_flag_set_a: assert property (
      event_set[BIT_ID] |=> otg_event_flags[BIT_ID])
      else $error("id change flag not set");
   ms_flag_set_a: assert property (
      ms_tick |=> otg_event_flags[BIT_MS])
      else $error("ms timer flag not set");
   flag_clear_a: assert property (
      clear_all_s |=> otg_event_flags == 16'h0000)
      else $error("write one did not clear");
   flag_hold_a: assert property (
      (!WR_IN || ADDR_IN != ADDR_EVENT_FLAGS) && otg_event_flags[BIT_ACT]
      |=> otg_event_flags[BIT_ACT])
      else $error("flag lost without clear");
   reserved_zero_a: assert property (
      (otg_event_flags & ~MASK_EVENTS) == 16'h0000
      && (otg_event_enables & ~MASK_EVENTS) == 16'h0000)
      else $error("unimplemented bit set");
   irq_follow_a: assert property (
      (event_set & otg_event_enables) != 16'h0000
      && !wr_hit(ADDR_IN, ADDR_EVENT_EN, WR_IN) |=> OTG_IRQ_OUT)
      else $error("irq not raised for enabled event");
   vbus_edge_a: assert property (
      $changed(sync_b.a_vbus_valid) |=> otg_event_flags[BIT_AVBUS])
      else $error("vbus crossing missed");
   monitor_gate_a: assert property (
      !usb_config_two[BIT_XCVR_DIS] |=> !DRIVE_MONITOR_OUT)
      else $error("monitor active with transceiver on");
   run_power_a: assert property (
      !module_power_enable |=> !MODULE_RUN_OUT)
      else $error("running while unpowered");

   // set paths of the remaining flags and configuration follow-through
   // flag next cycle, and the new state becomes the recorded one
   sequence line_settled_s;
      ##1 (otg_event_flags[BIT_LINE] && line_recorded == line_seen);
   endsequence
   line_stable_a: assert property (
      line_event |-> line_settled_s)
      else $error("stable line change not flagged");
   act_flag_set_a: assert property (
      event_set[BIT_ACT] |=> otg_event_flags[BIT_ACT])
      else $error("activity flag not set");
   sess_flag_set_a: assert property (
      $changed(sync_b.a_sess_end) |=> otg_event_flags[BIT_SESSV])
      else $error("a session end crossing missed");
   bsess_flag_set_a: assert property (
      $changed(sync_b.b_sess_end) |=> otg_event_flags[BIT_BSEND])
      else $error("b session end crossing missed");
   unmapped_read_a: assert property (
      RD_IN && ADDR_IN > ADDR_POWER |=> RDATA_OUT == 16'h0000)
      else $error("unmapped index read nonzero");
   halt_idle_a: assert property (
      usb_config_one[BIT_HALT_IDLE] && IDLE_MODE_IN |=> !MODULE_RUN_OUT)
      else $error("module ran while halted in idle");
   eye_follow_a: assert property (
      usb_config_one[BIT_EYE] |=> EYE_TEST_OUT)
      else $error("eye test not driven");
   boost_follow_a: assert property (
      usb_config_two[BIT_BOOST_DIS] |=> BOOST_DISABLE_OUT)
      else $error("boost not disabled");
   vcmp_follow_a: assert property (
      usb_config_two[BIT_VCMP_DIS] |=> VCMP_DISABLE_OUT)
      else $error("comparator not disabled");
   xcvr_follow_a: assert property (
      usb_config_two[BIT_XCVR_DIS] |=> XCVR_DISABLE_OUT)
      else $error("transceiver not disabled");
endmodule : usb_otg_config_irq_regs

// ===== src/otg_regs_pkg.sv
// package: register map, field positions and timing for the otg config block
package otg_regs_pkg;
   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [3:0] ADDR_FRAME_THR = 4'h0;
   localparam logic [3:0] ADDR_CONFIG_ONE = 4'h1;
   localparam logic [3:0] ADDR_CONFIG_TWO = 4'h2;
   localparam logic [3:0] ADDR_EVENT_FLAGS = 4'h3;
   localparam logic [3:0] ADDR_EVENT_EN = 4'h4;
   localparam logic [3:0] ADDR_POWER = 4'h5;
   // implemented bit masks
   localparam logic [15:0] MASK_FRAME_THR = 16'h00ff;
   localparam logic [15:0] MASK_CONFIG_ONE = 16'h00d3;
   localparam logic [15:0] MASK_CONFIG_TWO = 16'h001f;
   localparam logic [15:0] MASK_EVENTS = 16'h00fd;
   localparam logic [15:0] MASK_POWER = 16'h0001;
   localparam logic [15:0] RESET_VALUE = 16'h0000;
   localparam logic [7:0] FRAME_OVERHEAD = 8'h0a;
   // field positions
   localparam int BIT_EYE = 7;
   localparam int BIT_DRVMON = 6;
   localparam int BIT_HALT_IDLE = 4;
   localparam int BIT_PULLUP = 4;
   localparam int BIT_SERIAL_SEL = 3;
   localparam int BIT_BOOST_DIS = 2;
   localparam int BIT_VCMP_DIS = 1;
   localparam int BIT_XCVR_DIS = 0;
   localparam int BIT_ID = 7;
   localparam int BIT_MS = 6;
   localparam int BIT_LINE = 5;
   localparam int BIT_ACT = 4;
   localparam int BIT_SESSV = 3;
   localparam int BIT_BSEND = 2;
   localparam int BIT_AVBUS = 0;
   // timing
   localparam int CLOCK_HZ = 40000000;
   localparam int MS_TIME_US = 1000;
   localparam int MS_CYCLES = CLOCK_HZ / 1000000 * MS_TIME_US;
   localparam int NUM_INPUTS = 8;
   // ping-pong selections
   typedef enum logic [1:0] {
      PP_NONE_type, PP_OUT0_type, PP_ALL_type, PP_SUBSET_type
   } pingpong_type;
   // bundled pin inputs
   typedef struct packed {
      logic id_pin;
      logic dplus;
      logic dminus;
      logic vbus_act;
      logic a_sess_end;
      logic b_sess_end;
      logic a_vbus_valid;
      logic both_lines_low;
   } sense_type;
endpackage : otg_regs_pkg

// ===== test/otg_line_model.sv
// model of the usb lines and vbus sensing that feed the block
module otg_line_model
   import otg_regs_pkg::*;
(
   // clock, reset and toggle request
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] flip_in,
   // pin levels seen by the block
   output sense_type sense_out
);
   logic [7:0] level;
   // --------------------------------------------------------------
   // pin levels
   // --------------------------------------------------------------
   // levels move only when asked, so every event is one clean edge
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         level <= 8'h00;
      end else begin
         level <= level ^ flip_in;
      end
   end
   assign sense_out = sense_type'(level);
endmodule : otg_line_model

// ===== test/usb_otg_config_irq_regs_tb.sv
// self-checking bench for the otg configuration and event registers
module usb_otg_config_irq_regs_tb
   import otg_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, wr, rd, idle, drv;
   logic eye, mon, run, pull, ser, boost, vcmp, xcvr, irq;
   logic [3:0] addr, ra;
   logic [15:0] wdata, rdata, v, w;
   logic [7:0] thr, flip;
   pingpong_type pp;
   sense_type sense;
   int errors, cmp_count, cycles, i;
   logic [7:0] ev_pin [6] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02};
   logic [15:0] ev_flag [6] = '{16'h80, 16'h10, 16'h10, 16'h08, 16'h04,
                                16'h01};
   otg_line_model line (.clk_in(mclk), .rst_in(rst), .flip_in(flip),
      .sense_out(sense));
   usb_otg_config_irq_regs uut (.MCLK_IN(mclk), .RST_IN(rst),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .RDATA_OUT(rdata), .SENSE_IN(sense), .IDLE_MODE_IN(idle),
      .LINE_DRIVING_IN(drv), .EYE_TEST_OUT(eye), .DRIVE_MONITOR_OUT(mon),
      .MODULE_RUN_OUT(run), .PINGPONG_OUT(pp), .VBUS_PULLUP_OUT(pull),
      .SERIAL_CTRL_OUT(ser), .BOOST_DISABLE_OUT(boost),
      .VCMP_DISABLE_OUT(vcmp), .XCVR_DISABLE_OUT(xcvr),
      .FRAME_THRESHOLD_OUT(thr), .OTG_IRQ_OUT(irq));
   // --------------------------------------------------------------
   // clock and hang guard
   // --------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // the long timer test needs about 40100 cycles of the budget
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         give_verdict();
      end
   end
   // --------------------------------------------------------------
   // bus tasks, expectations and compares
   // --------------------------------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : settle
   task automatic pulse(input logic [7:0] m);
      @(posedge mclk);
      flip <= m;
      @(posedge mclk);
      flip <= 8'h00;
   endtask : pulse
   function automatic logic [15:0] exp_mask(input logic [3:0] a);
      case (a)
         ADDR_FRAME_THR: return MASK_FRAME_THR;
         ADDR_CONFIG_ONE: return MASK_CONFIG_ONE;
         ADDR_CONFIG_TWO: return MASK_CONFIG_TWO;
         ADDR_EVENT_EN: return MASK_EVENTS;
         ADDR_POWER: return MASK_POWER;
         default: return 16'h0000;
      endcase
   endfunction : exp_mask
   function automatic logic [15:0] frame_value(input logic [7:0] n);
      return {8'h00, n + FRAME_OVERHEAD};
   endfunction : frame_value
   task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_word
   task automatic chk_pin(input logic g, input logic e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] t=%0t pin got %h exp %h", $time, g, e);
      end
   endtask : chk_pin
   task automatic give_verdict();
      $display("counts: %0d compares, %0d errors", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {wr, rd, idle, drv, addr, wdata, flip} = '0;
      void'($urandom(32'h42282bf4));
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i < 16; i++) begin
         rd_reg(4'(i), v);
         chk_word(v, RESET_VALUE);
      end
      $display("test reset values done");
      // power stays off so software may touch the disable bits
      for (i = 0; i < 60; i++) begin
         ra = 4'($urandom_range(15, 0));
         if (ra == ADDR_EVENT_FLAGS || ra == ADDR_POWER) begin
            ra = ADDR_CONFIG_TWO;
         end
         w = 16'($urandom());
         wr_reg(ra, w);
         rd_reg(ra, v);
         chk_word(v, w & exp_mask(ra));
      end
      $display("test random access done");
      for (i = 0; i < 4; i++) begin
         w = frame_value(i == 0 ? 8'd64 : 8'($urandom_range(245, 0)));
         wr_reg(ADDR_FRAME_THR, w);
         settle(2);
         chk_word({8'h00, thr}, w);
         wr_reg(ADDR_CONFIG_ONE, 16'(i));
         settle(2);
         chk_word({14'h0, pp}, 16'(i));
      end
      for (i = 0; i < 5; i++) begin
         wr_reg(ADDR_CONFIG_TWO, 16'h0001 << i);
         settle(2);
         v = {11'h0, pull, ser, boost, vcmp, xcvr};
         chk_word(v, 16'h1 << i);
      end
      $display("test config fields done");
      @(posedge mclk);
      drv <= 1'b1;
      wr_reg(ADDR_CONFIG_ONE, 16'h00c0);
      wr_reg(ADDR_CONFIG_TWO, 16'h0000);
      settle(2);
      chk_pin(eye, 1'b1);
      chk_pin(mon, 1'b0);
      wr_reg(ADDR_CONFIG_TWO, 16'h0001);
      settle(2);
      chk_pin(mon, 1'b1);
      @(posedge mclk);
      drv <= 1'b0;
      wr_reg(ADDR_CONFIG_ONE, 16'h0010);
      settle(2);
      chk_pin(mon, 1'b0);
      chk_pin(eye, 1'b0);
      wr_reg(ADDR_POWER, 16'h0001);
      settle(2);
      chk_pin(run, 1'b1);
      @(posedge mclk);
      idle <= 1'b1;
      settle(3);
      chk_pin(run, 1'b0);
      @(posedge mclk);
      idle <= 1'b0;
      wr_reg(ADDR_POWER, 16'h0000);
      settle(3);
      chk_pin(run, 1'b0);
      $display("test run control done");
      wr_reg(ADDR_EVENT_EN, 16'h00fd);
      for (i = 0; i < 12; i++) begin
         pulse(ev_pin[i % 6]);
         settle(6);
         rd_reg(ADDR_EVENT_FLAGS, v);
         chk_word(v, ev_flag[i % 6]);
         // enables are cleared after the first round of events
         chk_pin(irq, i < 6);
         wr_reg(ADDR_EVENT_FLAGS, ~ev_flag[i % 6]);
         rd_reg(ADDR_EVENT_FLAGS, v);
         chk_word(v, ev_flag[i % 6]);
         wr_reg(ADDR_EVENT_FLAGS, ev_flag[i % 6]);
         settle(1);
         chk_pin(irq, 1'b0);
         if (i == 5) begin
            wr_reg(ADDR_EVENT_EN, 16'h0000);
         end
      end
      rd_reg(ADDR_EVENT_FLAGS, v);
      chk_word(v, 16'h0000);
      $display("test event flags done");
      wr_reg(ADDR_EVENT_EN, 16'h0060);
      pulse(8'h40);
      wr_reg(ADDR_POWER, 16'h0001);
      settle(39900);
      rd_reg(ADDR_EVENT_FLAGS, v);
      chk_word(v & 16'h0060, 16'h0000);
      settle(200);
      rd_reg(ADDR_EVENT_FLAGS, v);
      chk_word(v & 16'h0060, 16'h0060);
      chk_pin(irq, 1'b1);
      wr_reg(ADDR_EVENT_FLAGS, 16'hffff);
      rd_reg(ADDR_EVENT_FLAGS, v);
      chk_word(v, 16'h0000);
      chk_pin(irq, 1'b0);
      $display("test millisecond events done");
      give_verdict();
   end
endmodule : usb_otg_config_irq_regs_tb
